// File: pkg/wlsg_pkg.sv
// Constants, opcodes and types of the write latch and sector guard block.
// Assumes an SPI host in mode 0 or 3 that frames each command with chip select.
package wlsg_pkg;

  // Command opcodes.
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_GUARD_SET = 8'h36;
  localparam logic [7:0] OP_GUARD_CLR = 8'h39;

  // Address layout: 24-bit location, sector number in bits 19..16.
  localparam int ADDR_W = 24;
  localparam int SECT_LSB = 16;
  localparam int SECT_W = 4;
  localparam int N_SECT = 16;

  // Frame counting: opcode byte plus three address bytes.
  localparam logic [2:0] CMD_BYTES = 3'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Reset values.
  localparam logic GUARD_RST = 1'b1;
  localparam logic LATCH_RST = 1'b0;
  localparam logic [1:0] SYNC_RST = 2'h3;

  typedef enum logic {
    WLSG_IDLE = 1'b0,
    WLSG_FRAME = 1'b1
  } wlsg_state_e;

endpackage

// File: pkg/wlsg_link_if.sv
// Frame snapshot passed from the serial-clock logic to the system-clock logic.
// Assumes the fields are read only after chip select has been seen high.
`timescale 1ns/100ps
`default_nettype none
interface wlsg_link_if;
  import wlsg_pkg::*;
  logic [7:0] opcode;
  logic [ADDR_W-1:0] addr;
  logic [2:0] bits;
  logic [2:0] bytes;
  logic ftog;
  modport link (output opcode, addr, bits, bytes, ftog);
  modport core (input opcode, addr, bits, bytes, ftog);
endinterface
`default_nettype wire

// File: rtl/wlsg_link.sv
// Serial-clock side: shifts in opcode and address and counts bits per frame.
// Assumes sck only toggles while chip select is low; data sampled on rising sck.
`timescale 1ns/100ps
`default_nettype none
module wlsg_link import wlsg_pkg::*; (
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  wlsg_link_if.link lnk
);

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic started;
  } wlsg_frm_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [2:0] bits;
    logic [2:0] bytes;
    logic ftog;
  } wlsg_snap_s;

  wlsg_frm_s frm_reg;
  wlsg_frm_s frm_next;
  wlsg_snap_s snap_reg;
  wlsg_snap_s snap_next;

  always_comb begin
    frm_next = frm_reg;
    snap_next = snap_reg;
    frm_next.started = 1'b1;
    frm_next.bit_cnt = frm_reg.bit_cnt + 3'h1;
    // The byte count stops at a full command so later bytes are ignored.
    if (frm_reg.bit_cnt == BIT_LAST && frm_reg.byte_cnt != CMD_BYTES) begin // R07 R11
      frm_next.byte_cnt = frm_reg.byte_cnt + 3'h1;
    end
    // A toggle marks each frame that carried at least one clock edge.
    if (!frm_reg.started) begin
      snap_next.ftog = ~snap_reg.ftog;
    end
    if (frm_reg.byte_cnt == 3'h0) begin
      snap_next.opcode = {snap_reg.opcode[6:0], mosi_in};
    end else if (frm_reg.byte_cnt != CMD_BYTES) begin // R07 R11
      snap_next.addr = {snap_reg.addr[ADDR_W-2:0], mosi_in};
    end
    snap_next.bits = frm_next.bit_cnt;
    snap_next.bytes = frm_next.byte_cnt;
  end

  // Frame counters clear while chip select is high, with no sck edge needed.
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      frm_reg <= '0;
    end else begin
      frm_reg <= frm_next;
    end
  end

  // The snapshot survives the end of the frame for the system side to read.
  always_ff @(posedge sck_in or posedge rst_in) begin
    if (rst_in) begin
      snap_reg <= '0;
    end else begin
      snap_reg <= snap_next;
    end
  end

  assign lnk.opcode = snap_reg.opcode;
  assign lnk.addr = snap_reg.addr;
  assign lnk.bits = snap_reg.bits;
  assign lnk.bytes = snap_reg.bytes;
  assign lnk.ftog = snap_reg.ftog;

endmodule
`default_nettype wire

// File: rtl/wlsg_top.sv
// Write latch and per-sector guard flags, driven by serial commands.
// Assumes the lock and suspend inputs and the operation address come from
// logic on clk_in; the serial pins are asynchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none

// How it works
// (R01) Guarded commands execute only when the write latch was already set.
// (R02) Opcode 06h, whole bytes, sets the write latch at chip select release.
// (R03) Latch commands ended mid-byte or before the opcode leave the latch alone.
// (R04) Opcode 04h, whole bytes, clears the write latch at chip select release.
// (R05) One guard flag per 64KB sector, all set to protected at power-up.
// (R06) A clear flag permits program and erase; a set flag blocks both.
// (R07) Opcode 36h takes three address bytes; later bytes are ignored.
// (R08) Protect sets the addressed sector flag and clears the write latch.
// (R09) A truncated protect keeps the flag but still clears the latch.
// (R10) Opcode 39h with three address bytes clears the flag and the latch.
// (R11) Bytes after the unprotect address are ignored.
// (R12) A truncated unprotect keeps the flag but still clears the latch.
// (R13) With the lock bit set, protect changes no flag but clears the latch.
// (R14) With the lock bit set, unprotect changes no flag but clears the latch.
// (R15) Host sets the latch first and ends frames on whole bytes.
// (R16) While suspended, sector commands are ignored and the latch is untouched.
// (R17) Address bits 19 to 16 choose one of sixteen sectors.
module wlsg_top import wlsg_pkg::*; #(
  parameter int SECTORS = N_SECT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic protection_lock_bit_in,
  input wire logic prog_susp_in,
  input wire logic erase_susp_in,
  input wire logic [ADDR_W-1:0] op_addr_in,
  output logic write_latch_out,
  output logic [SECTORS-1:0] sector_write_guard_out,
  output logic op_permit_out,
  output logic frame_busy_out
);

  if (SECTORS != (1 << SECT_W)) begin : g_bad_sectors
    $error("SECTORS must equal two to the power of the sector field width");
  end

  if (SECT_LSB + SECT_W > ADDR_W) begin : g_bad_field
    $error("the sector field must lie inside the address");
  end

  typedef struct packed {
    logic [1:0] cs_sync;
    wlsg_state_e state;
    logic ftog_seen;
    logic latch;
    logic [SECTORS-1:0] guard;
    logic permit;
    logic busy;
  } wlsg_core_s;

  localparam wlsg_core_s CORE_RST = '{
    cs_sync: SYNC_RST,
    state: WLSG_IDLE,
    ftog_seen: 1'b0,
    latch: LATCH_RST,
    guard: {SECTORS{GUARD_RST}},
    permit: 1'b0,
    busy: 1'b0
  };

  wlsg_core_s st_reg;
  wlsg_core_s st_next;

  // The link logic runs on sck and hands over a snapshot that is not
  // synchronised: it is read only while the synchronised chip select shows high
  // and sck stands still. Chip select must stay low for three clk_in periods.
  wlsg_link_if lnk_if ();

  wlsg_link wlsg_link_inst (
    .rst_in(rst_in),
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .lnk(lnk_if.link)
  );

  // Decode of a finished frame. The snapshot is read only once the
  // synchronised chip select shows high, by then sck has stood still.
  logic cs_high;
  logic frame_end;
  logic ex_go;
  logic ex_whole;
  logic ex_full;
  logic ex_guard_op;
  logic any_susp;
  logic [SECT_W-1:0] ex_sect;
  logic [SECT_W-1:0] op_sect;

  assign cs_high = st_reg.cs_sync[1];
  assign frame_end = (st_reg.state == WLSG_FRAME) && cs_high;
  // A frame with no sck edge leaves the toggle alone and does nothing.
  assign ex_go = frame_end && (lnk_if.ftog != st_reg.ftog_seen) && (lnk_if.bytes != 3'h0);
  assign ex_whole = (lnk_if.bits == 3'h0); // R03
  assign ex_full = ex_whole && (lnk_if.bytes == CMD_BYTES); // R09 R12
  assign ex_guard_op = (lnk_if.opcode == OP_GUARD_SET) || (lnk_if.opcode == OP_GUARD_CLR);
  assign any_susp = prog_susp_in | erase_susp_in;
  assign ex_sect = lnk_if.addr[SECT_LSB +: SECT_W]; // R17
  assign op_sect = op_addr_in[SECT_LSB +: SECT_W]; // R17

  // Named decodes of a finished frame, used by the checks below.
  logic ex_latch_cmd;
  logic ex_prot;
  logic ex_unprot;
  logic ex_guard_ok;
  logic [SECTORS-1:0] ex_mask;

  assign ex_latch_cmd = (lnk_if.opcode == OP_LATCH_SET) || (lnk_if.opcode == OP_LATCH_CLR);
  assign ex_prot = ex_go && (lnk_if.opcode == OP_GUARD_SET);
  assign ex_unprot = ex_go && (lnk_if.opcode == OP_GUARD_CLR);
  assign ex_guard_ok = ex_full && st_reg.latch && !protection_lock_bit_in && !any_susp;
  assign ex_mask = {{(SECTORS-1){1'b0}}, 1'b1} << ex_sect;

  always_comb begin
    st_next = st_reg;
    st_next.cs_sync = {st_reg.cs_sync[0], cs_n_in};
    st_next.busy = ~cs_high;
    // Program and erase need the latch and a clear guard flag.
    st_next.permit = st_reg.latch & ~st_reg.guard[op_sect]; // R01 R06
    unique case (st_reg.state)
      WLSG_IDLE: begin
        if (!cs_high) begin
          st_next.state = WLSG_FRAME;
        end
      end
      WLSG_FRAME: begin
        if (cs_high) begin
          st_next.state = WLSG_IDLE;
          st_next.ftog_seen = lnk_if.ftog;
        end
      end
    endcase
    if (ex_go) begin
      case (lnk_if.opcode)
        OP_LATCH_SET: begin
          // Latch commands are refused only during a program suspend.
          if (ex_whole && !prog_susp_in) begin // R02 R03 R16
            st_next.latch = 1'b1;
          end
        end
        OP_LATCH_CLR: begin
          if (ex_whole && !prog_susp_in) begin // R04 R03 R16
            st_next.latch = 1'b0;
          end
        end
        OP_GUARD_SET,
        OP_GUARD_CLR: begin
          if (!any_susp) begin // R16
            st_next.latch = 1'b0; // R08 R09 R10 R12 R13 R14
            if (ex_full && st_reg.latch && !protection_lock_bit_in) begin // R01 R13 R14
              st_next.guard[ex_sect] = (lnk_if.opcode == OP_GUARD_SET); // R08 R10
            end
          end
        end
        default: begin
          st_next.latch = st_reg.latch;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= CORE_RST; // R05
    end else begin
      st_reg <= st_next;
    end
  end

  assign write_latch_out = st_reg.latch;
  assign sector_write_guard_out = st_reg.guard;
  assign op_permit_out = st_reg.permit;
  assign frame_busy_out = st_reg.busy;

  // Checks sample on clk_in; they look at the link snapshot only at a frame
  // end, when it stands still.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // All sectors come out of reset protected and the latch clear.
  guard_powerup_a: assert property ( // R05
    $past(rst_in) |-> (&st_reg.guard) && !st_reg.latch)
    else $error("guard flags or latch wrong after reset");

  latch_set_a: assert property ( // R02
    ex_go && lnk_if.opcode == OP_LATCH_SET && ex_whole && !prog_susp_in
    |=> write_latch_out [*2])
    else $error("latch set command did not set the latch");

  latch_clr_a: assert property ( // R04
    ex_go && lnk_if.opcode == OP_LATCH_CLR && ex_whole && !prog_susp_in |=> !write_latch_out)
    else $error("latch clear command did not clear the latch");

  latch_short_a: assert property ( // R03
    ex_go && !ex_whole
    && (lnk_if.opcode == OP_LATCH_SET || lnk_if.opcode == OP_LATCH_CLR)
    |=> $stable(write_latch_out))
    else $error("partial latch command changed the latch");

  guard_set_a: assert property ( // R08
    ex_go && lnk_if.opcode == OP_GUARD_SET && ex_full && st_reg.latch
    && !protection_lock_bit_in && !any_susp
    |=> sector_write_guard_out[$past(ex_sect)] && !write_latch_out)
    else $error("protect did not set the flag and clear the latch");

  guard_clr_a: assert property ( // R10
    ex_go && lnk_if.opcode == OP_GUARD_CLR && ex_full && st_reg.latch
    && !protection_lock_bit_in && !any_susp
    |=> !sector_write_guard_out[$past(ex_sect)] && !write_latch_out)
    else $error("unprotect did not clear the flag and the latch");

  guard_trunc_a: assert property ( // R09 R12
    ex_go && ex_guard_op && !ex_full && !any_susp
    |=> $stable(sector_write_guard_out) && !write_latch_out)
    else $error("truncated sector command misbehaved");

  guard_lock_a: assert property ( // R13 R14
    ex_go && ex_guard_op && protection_lock_bit_in && !any_susp
    |=> $stable(sector_write_guard_out) && !write_latch_out)
    else $error("locked sector command misbehaved");

  susp_ignore_a: assert property ( // R16
    ex_go && ex_guard_op && any_susp
    |=> $stable(sector_write_guard_out) && $stable(write_latch_out))
    else $error("sector command acted while suspended");

  guard_needs_latch_a: assert property ( // R01
    !$stable(sector_write_guard_out) |-> $past(st_reg.latch) && !write_latch_out)
    else $error("guard flag changed without the latch");

  permit_block_a: assert property ( // R06
    st_reg.guard[op_sect] || !st_reg.latch |=> !op_permit_out)
    else $error("program permitted on a protected sector");

  frame_close_a: assert property ( // R13 R14
    frame_end |=> st_reg.state == WLSG_IDLE ##1 !frame_end)
    else $error("frame end not taken in one cycle");

  // Checks on what alone may move the latch, the flags and the status outputs.
  latch_quiet_a: assert property ( // R02 R04
    !ex_go
    |=> $stable(write_latch_out))
    else $error("latch moved with no command acted on");

  guard_quiet_a: assert property ( // R08 R10
    !ex_go
    |=> $stable(sector_write_guard_out))
    else $error("guard flags moved with no command acted on");

  one_sector_a: assert property ( // R17
    $onehot0(sector_write_guard_out ^ $past(sector_write_guard_out)))
    else $error("more than one guard flag moved at once");

  sector_target_a: assert property ( // R17
    ex_go
    |=> ((sector_write_guard_out ^ $past(sector_write_guard_out)) & ~$past(ex_mask)) == '0)
    else $error("a guard flag outside the addressed sector moved");

  prot_exact_a: assert property ( // R08
    ex_prot && ex_guard_ok
    |=> sector_write_guard_out == ($past(sector_write_guard_out) | $past(ex_mask)))
    else $error("protect did not set exactly the addressed flag");

  unprot_exact_a: assert property ( // R10
    ex_unprot && ex_guard_ok
    |=> sector_write_guard_out == ($past(sector_write_guard_out) & ~$past(ex_mask)))
    else $error("unprotect did not clear exactly the addressed flag");

  latch_susp_a: assert property ( // R16
    ex_go && ex_latch_cmd && prog_susp_in
    |=> $stable(write_latch_out))
    else $error("latch command acted during a program suspend");

  latch_esus_a: assert property ( // R16
    ex_go && lnk_if.opcode == OP_LATCH_CLR && ex_whole && erase_susp_in && !prog_susp_in
    |=> !write_latch_out)
    else $error("latch clear refused during an erase suspend");

  lock_hold_a: assert property ( // R13 R14
    $past(protection_lock_bit_in)
    |-> $stable(sector_write_guard_out))
    else $error("guard flags moved while locked");

  guard_no_latch_a: assert property ( // R01
    ex_go && ex_guard_op && !st_reg.latch
    |=> $stable(sector_write_guard_out) && !write_latch_out)
    else $error("sector command acted without the latch");

  guard_drop_a: assert property ( // R09 R12
    ex_go && ex_guard_op && !any_susp
    |=> !write_latch_out)
    else $error("sector command left the latch set");

  short_frame_a: assert property ( // R03
    frame_end && lnk_if.bytes == 3'h0
    |=> $stable(write_latch_out) && $stable(sector_write_guard_out))
    else $error("frame without a whole opcode acted");

  other_op_a: assert property ( // R01
    ex_go && !ex_latch_cmd && !ex_guard_op
    |=> $stable(write_latch_out) && $stable(sector_write_guard_out))
    else $error("unknown opcode acted");

  frame_track_a: assert property ( // R13 R14
    !cs_high
    |=> frame_busy_out && st_reg.state == WLSG_FRAME)
    else $error("selected frame not tracked");

  idle_stay_a: assert property ( // R13 R14
    cs_high && st_reg.state == WLSG_IDLE
    |=> st_reg.state == WLSG_IDLE && !frame_busy_out)
    else $error("left idle with chip select high");

  permit_grant_a: assert property ( // R06
    st_reg.latch && !st_reg.guard[op_sect]
    |=> op_permit_out)
    else $error("program refused on an unprotected sector");

  permit_follow_a: assert property ( // R01
    op_permit_out
    |-> $past(st_reg.latch))
    else $error("program permitted without the latch");

  permit_reset_a: assert property ( // R05
    $past(rst_in)
    |-> !op_permit_out && !frame_busy_out)
    else $error("status outputs wrong after reset");

  latch_set_c: cover property (
    ex_go && lnk_if.opcode == OP_LATCH_SET && ex_whole ##1 write_latch_out);
  guard_set_c: cover property (
    ex_go && lnk_if.opcode == OP_GUARD_SET && ex_full && st_reg.latch);
  guard_clr_c: cover property (
    ex_go && lnk_if.opcode == OP_GUARD_CLR && ex_full && st_reg.latch);
  guard_lock_c: cover property (
    ex_go && ex_guard_op && protection_lock_bit_in && st_reg.latch);
  guard_susp_c: cover property (
    ex_go && ex_guard_op && any_susp ##1 write_latch_out);

endmodule
`default_nettype wire

// File: verification/wlsg_host.sv
// SPI host model that frames commands for the write latch and sector guard block.
// Assumes the caller keeps frames apart; mode 0, sck idle low and still between frames.
`timescale 1ns/100ps
`default_nettype none
module wlsg_host (
  output logic sck_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // Sends the first nbits of data, MSB first; a count off a byte boundary cuts a frame short.
  task automatic frame(input logic [39:0] data, input int nbits);
    cs_n_out = 1'b0;
    // Chip select leads the first sck edge by three clk_in periods, so that
    // the block's synchroniser sees even the shortest frame.
    #150;
    for (int i = 0; i < nbits; i++) begin
      mosi_out = data[39-i];
      #3 sck_out = 1'b1;
      #3 sck_out = 1'b0;
    end
    #3 cs_n_out = 1'b1;
    // The data line no longer holds the last bit once the frame is over.
    mosi_out = ~mosi_out;
  endtask
endmodule
`default_nettype wire

// File: verification/wlsg_top_test.sv
// Self-checking bench for the write latch and sector guard block.
// Assumes the host model frames commands; lock and suspend inputs change on falling clk_in.
`timescale 1ns/100ps
`default_nettype none
module wlsg_top_test import wlsg_pkg::*;;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  wire logic sck;
  wire logic cs_n;
  wire logic mosi;
  logic lock = 1'b0;
  logic psus = 1'b0;
  logic esus = 1'b0;
  logic [ADDR_W-1:0] op_addr = 24'h000000;
  logic latch;
  logic permit;
  logic busy;
  logic [15:0] guard;
  int num_errors = 0;
  int n_tests = 0;

  always #25 clk_in = ~clk_in;

  wlsg_host wlsg_host_inst (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi));

  wlsg_top #(.SECTORS(16)) wlsg_top_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sck_in(sck),
    .cs_n_in(cs_n),
    .mosi_in(mosi),
    .protection_lock_bit_in(lock),
    .prog_susp_in(psus),
    .erase_susp_in(esus),
    .op_addr_in(op_addr),
    .write_latch_out(latch),
    .sector_write_guard_out(guard),
    .op_permit_out(permit),
    .frame_busy_out(busy)
  );

  task automatic give_verdict();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Sends one frame, waits for the block to act on it, then checks latch and flags.
  task automatic step(input logic [7:0] op, input logic [31:0] rest, input int n,
                      input logic el, input logic [15:0] eg);
    int i;
    wlsg_host_inst.frame({op, rest}, n);
    @(negedge clk_in);
    check({15'h0000, busy}, 16'h0001);
    i = 0;
    while (busy !== 1'b0 && i < 10) begin
      @(negedge clk_in);
      i++;
    end
    if (busy !== 1'b0) begin
      num_errors++;
      give_verdict();
    end
    repeat (2) @(negedge clk_in);
    check({15'h0000, latch}, {15'h0000, el});
    check(guard, eg);
  endtask

  task automatic perm(input logic [23:0] a, input logic ep);
    op_addr = a;
    repeat (2) @(negedge clk_in);
    check({15'h0000, permit}, {15'h0000, ep});
  endtask

  initial begin
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    check(guard, 16'hFFFF);
    check({14'h0000, latch, busy}, 16'h0000);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFFF);
    step(8'h04, 32'hA5000000, 16, 1'b0, 16'hFFFF);
    step(8'h06, 32'h5A000000, 16, 1'b1, 16'hFFFF);
    step(8'h04, 32'h00000000, 7, 1'b1, 16'hFFFF);
    step(8'h04, 32'h00000000, 12, 1'b1, 16'hFFFF);
    step(8'h04, 32'h00000000, 8, 1'b0, 16'hFFFF);
    step(8'h39, 32'hF3000000, 32, 1'b0, 16'hFFFF);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFFF);
    step(8'h39, 32'hF3123400, 32, 1'b0, 16'hFFF7);
    perm(24'h031000, 1'b0);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFF7);
    perm(24'hF3ABCD, 1'b1);
    perm(24'h040000, 1'b0);
    step(8'h39, 32'hA5FFFF36, 40, 1'b0, 16'hFFD7);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFD7);
    step(8'h39, 32'h06000000, 28, 1'b0, 16'hFFD7);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFD7);
    step(8'h39, 32'h06000000, 36, 1'b0, 16'hFFD7);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFD7);
    step(8'h36, 32'h030000C3, 40, 1'b0, 16'hFFDF);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFDF);
    step(8'h36, 32'h05000000, 24, 1'b0, 16'hFFDF);
    lock = 1'b1;
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFDF);
    step(8'h39, 32'h07000000, 32, 1'b0, 16'hFFDF);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFDF);
    step(8'h36, 32'h05000000, 32, 1'b0, 16'hFFDF);
    lock = 1'b0;
    esus = 1'b1;
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFDF);
    step(8'h39, 32'h0A000000, 32, 1'b1, 16'hFFDF);
    esus = 1'b0;
    psus = 1'b1;
    step(8'h04, 32'h00000000, 8, 1'b1, 16'hFFDF);
    step(8'h36, 32'h05000000, 32, 1'b1, 16'hFFDF);
    psus = 1'b0;
    step(8'h04, 32'h00000000, 8, 1'b0, 16'hFFDF);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFDF);
    rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    check(guard, 16'hFFFF);
    check({14'h0000, latch, busy}, 16'h0000);
    step(8'h06, 32'h00000000, 8, 1'b1, 16'hFFFF);
    step(8'hC7, 32'h00000000, 8, 1'b1, 16'hFFFF);
    give_verdict();
  end
endmodule
`default_nettype wire
